/* logic/ssw_regs.svh */
// timing constants of the supply supervisor and watchdog
// assumes a 100 MHz core clock; included by bare name
`ifndef SSW_REGS_SVH
`define SSW_REGS_SVH

`define SSW_CLK_NS 10
// time base tick period, in ns
`define SSW_TICK_NS 1000000
`define SSW_TICK_CYCLES ((`SSW_TICK_NS + `SSW_CLK_NS - 1) / `SSW_CLK_NS)
// reset delay period, in ms
`define SSW_DELAY_MS 200
`define SSW_SHORT_DELAY_MS 25
// watchdog timeout interval, in ms
`define SSW_TIMEOUT_MS 1600
`define SSW_MS_NS 1000000
`define SSW_DELAY_TICKS ((`SSW_DELAY_MS * `SSW_MS_NS) / `SSW_TICK_NS)
`define SSW_SHORT_DELAY_TICKS ((`SSW_SHORT_DELAY_MS * `SSW_MS_NS) / `SSW_TICK_NS)
`define SSW_TIMEOUT_TICKS ((`SSW_TIMEOUT_MS * `SSW_MS_NS) / `SSW_TICK_NS)

`endif

/* logic/ssw_pkg.sv */
// types of the supply supervisor and watchdog
// assumes nothing beyond a SystemVerilog compiler
package ssw_pkg;
  typedef enum logic [1:0] {
    st_hold,
    st_delay,
    st_run
  } ssw_state_t;
endpackage

/* logic/ssw_top.sv */
// supply supervisor with manual reset and edge-fed watchdog
// assumes all i_ pins other than i_clk/i_resetn are asynchronous to i_clk
`timescale 1ns/1ns
`include "ssw_regs.svh"

module ssw_top #(
  parameter int unsigned TICK_CYCLES = `SSW_TICK_CYCLES,
  parameter bit SHORT_DELAY = 1'b0,
  parameter int unsigned DELAY_TICKS = SHORT_DELAY ? `SSW_SHORT_DELAY_TICKS : `SSW_DELAY_TICKS,
  parameter int unsigned TIMEOUT_TICKS = `SSW_TIMEOUT_TICKS,
  parameter bit HAS_WATCHDOG = 1'b1,
  parameter bit LATCH_FREE = 1'b0,
  parameter bit HAS_HIGH_OUT = 1'b1
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_supply_good,
  input wire logic i_manual_reset_n,
  input wire logic i_watchdog_kick_in,
  input wire logic i_kick_floating,
  output logic o_reset_n,
  output logic o_reset,
  output ssw_pkg::ssw_state_t o_state
);
  import ssw_pkg::*;

  logic rst_s1;
  logic rst_s2;
  logic sup_s1;
  logic sup_s;
  logic mr_s1;
  logic mr_s;
  logic kick_s1;
  logic kick_s;
  logic kick_d;
  logic flt_s1;
  logic flt_s;
  logic [31:0] tb_cnt;
  logic tick;
  logic [31:0] dly_cnt;
  logic [31:0] wd_cnt;
  logic latched;
  ssw_state_t state;
  ssw_state_t next_state;
  logic cond_ok;
  logic kick_edge;
  logic kick;
  logic dly_done;
  logic wd_expire;
  logic latch_set;
  logic [2:0] kick_vld;

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  // pin synchronisers; power-up values are the safe ones (supply bad, manual low)
  always_ff @(posedge i_clk or negedge rst_s2) begin
    if (!rst_s2) begin
      sup_s1 <= 1'b0;
      sup_s <= 1'b0;
      mr_s1 <= 1'b0;
      mr_s <= 1'b0;
      kick_s1 <= 1'b0;
      kick_s <= 1'b0;
      kick_d <= 1'b0;
      flt_s1 <= 1'b0;
      flt_s <= 1'b0;
      kick_vld <= 3'h0;
    end else begin
      sup_s1 <= i_supply_good;
      sup_s <= sup_s1;
      mr_s1 <= i_manual_reset_n;
      mr_s <= mr_s1;
      kick_s1 <= i_watchdog_kick_in;
      kick_s <= kick_s1;
      kick_d <= kick_s;
      flt_s1 <= i_kick_floating;
      flt_s <= flt_s1;
      kick_vld <= {kick_vld[1:0], 1'b1}; // no edge until kick_d holds a real pin sample, else a high idle pin latches
    end
  end

  assign cond_ok = mr_s && sup_s;
  assign kick_edge = kick_vld[2] && (kick_s ^ kick_d);
  // a floating pin restarts the watchdog every cycle, so it can never expire
  assign kick = kick_edge || flt_s;
  assign tick = (tb_cnt == 32'(TICK_CYCLES - 1));
  assign dly_done = tick && (dly_cnt == 32'(DELAY_TICKS - 1));
  assign wd_expire = HAS_WATCHDOG && tick && !kick && (wd_cnt == 32'(TIMEOUT_TICKS - 1));
  assign latch_set = !LATCH_FREE && HAS_WATCHDOG && kick_edge && state != st_run;

  // free-running time base; delay granularity is one tick
  always_ff @(posedge i_clk or negedge rst_s2) begin
    if (!rst_s2) begin
      tb_cnt <= 32'h0;
    end else if (tick) begin
      tb_cnt <= 32'h0;
    end else begin
      tb_cnt <= tb_cnt + 32'h1;
    end
  end

  // kicks seen during reset stick it low until the block is reset
  always_ff @(posedge i_clk or negedge rst_s2) begin
    if (!rst_s2) begin
      latched <= 1'b0;
    end else if (latch_set) begin
      latched <= 1'b1;
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      st_hold: begin
        if (cond_ok && !latched) begin
          next_state = st_delay;
        end
      end
      st_delay: begin
        if (!cond_ok || latched || latch_set) begin
          next_state = st_hold;
        end else if (dly_done) begin
          next_state = st_run;
        end
      end
      st_run: begin
        if (!cond_ok) begin
          next_state = st_hold;
        end else if (wd_expire) begin
          next_state = st_delay;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_s2) begin
    if (!rst_s2) begin
      state <= st_hold;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge i_clk or negedge rst_s2) begin
    if (!rst_s2) begin
      dly_cnt <= 32'h0;
    end else if (state != st_delay || dly_done) begin
      dly_cnt <= 32'h0;
    end else if (tick) begin
      dly_cnt <= dly_cnt + 32'h1;
    end
  end

  always_ff @(posedge i_clk or negedge rst_s2) begin
    if (!rst_s2) begin
      wd_cnt <= 32'h0;
    end else if (state != st_run || next_state != st_run || kick || wd_expire) begin
      wd_cnt <= 32'h0;
    end else if (tick) begin
      wd_cnt <= wd_cnt + 32'h1;
    end
  end

  // outputs are registered from next_state so they track state exactly
  always_ff @(posedge i_clk or negedge rst_s2) begin
    if (!rst_s2) begin
      o_reset_n <= 1'b0;
      o_reset <= HAS_HIGH_OUT;
      o_state <= st_hold;
    end else begin
      o_reset_n <= (next_state == st_run);
      o_reset <= HAS_HIGH_OUT && (next_state != st_run);
      o_state <= next_state;
    end
  end

  sequence s_delay_done;
    state == st_delay && dly_done && cond_ok && !latched && !latch_set;
  endsequence

  sequence s_timeout;
    state == st_run && cond_ok && wd_expire;
  endsequence

  property p_complement;
    @(posedge i_clk) disable iff (!rst_s2)
      HAS_HIGH_OUT |-> (o_reset == !o_reset_n);
  endproperty
  a_complement: assert property (p_complement) else $error("high output not complement of low");

  property p_cond_hold;
    @(posedge i_clk) disable iff (!rst_s2)
      !cond_ok |=> !o_reset_n && state == st_hold;
  endproperty
  a_cond_hold: assert property (p_cond_hold) else $error("reset not held with bad inputs");

  property p_manual_force;
    @(posedge i_clk) disable iff (!rst_s2)
      !mr_s |=> !o_reset_n ##1 !o_reset_n || mr_s;
  endproperty
  a_manual_force: assert property (p_manual_force) else $error("manual reset did not force reset");

  property p_supply_drop;
    @(posedge i_clk) disable iff (!rst_s2)
      (state == st_run && !sup_s) |=> $fell(o_reset_n);
  endproperty
  a_supply_drop: assert property (p_supply_drop) else $error("supply drop did not reassert reset");

  property p_release;
    @(posedge i_clk) disable iff (!rst_s2)
      $rose(o_reset_n) |-> $past(state) == st_delay && $past(dly_done) && $past(sup_s);
  endproperty
  a_release: assert property (p_release) else $error("reset released without delay or supply");

  property p_delay_len;
    @(posedge i_clk) disable iff (!rst_s2)
      s_delay_done |=> o_reset_n && dly_cnt == 32'h0;
  endproperty
  a_delay_len: assert property (p_delay_len) else $error("delay end did not release reset");

  property p_timeout;
    @(posedge i_clk) disable iff (!rst_s2)
      s_timeout |=> !o_reset_n && state == st_delay && dly_cnt == 32'h0;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout did not start a delay period");

  property p_wd_reinit;
    @(posedge i_clk) disable iff (!rst_s2)
      wd_expire |=> wd_cnt == 32'h0;
  endproperty
  a_wd_reinit: assert property (p_wd_reinit) else $error("timeout left watchdog count");

  property p_kick_restart;
    @(posedge i_clk) disable iff (!rst_s2)
      (state == st_run && kick_edge) |=> wd_cnt == 32'h0;
  endproperty
  a_kick_restart: assert property (p_kick_restart) else $error("kick edge did not restart watchdog");

  property p_float;
    @(posedge i_clk) disable iff (!rst_s2)
      (flt_s && state == st_run && cond_ok) |=> o_reset_n;
  endproperty
  a_float: assert property (p_float) else $error("watchdog expired with floating input");

  property p_latch;
    @(posedge i_clk) disable iff (!rst_s2)
      (!LATCH_FREE && HAS_WATCHDOG && kick_edge && state != st_run) |=> latched ##1 !o_reset_n;
  endproperty
  a_latch: assert property (p_latch) else $error("kick during reset did not latch");

  property p_no_latch;
    @(posedge i_clk) disable iff (!rst_s2)
      LATCH_FREE |-> !latched;
  endproperty
  a_no_latch: assert property (p_no_latch) else $error("latch-free variant latched");

  property p_wd_clear;
    @(posedge i_clk) disable iff (!rst_s2)
      !o_reset_n |-> wd_cnt == 32'h0;
  endproperty
  a_wd_clear: assert property (p_wd_clear) else $error("watchdog counted during reset");

  property p_tick;
    @(posedge i_clk) disable iff (!rst_s2)
      tick |=> tb_cnt == 32'h0 ##1 tb_cnt == 32'h1 || TICK_CYCLES == 1;
  endproperty
  a_tick: assert property (p_tick) else $error("time base did not wrap");

  property p_low_out;
    @(posedge i_clk) disable iff (!rst_s2)
      o_reset_n |-> $past(cond_ok);
  endproperty
  a_low_out: assert property (p_low_out) else $error("reset released while a condition held");
endmodule // ssw_top

/* verif/ssw_cpu_model.sv */
// processor-side model that toggles the watchdog kick pin
// assumes the bench sets i_period to zero whenever kicks must stop
`timescale 1ns/1ns
module ssw_cpu_model (
  input wire logic i_clk,
  input wire logic [7:0] i_period,
  output logic o_kick
);
  logic [7:0] cnt;
  initial begin
    o_kick = 1'b0;
    cnt = 8'h00;
  end
  // period zero parks the pin at its last level, as a hung processor would
  always @(posedge i_clk) begin
    if (i_period == 8'h00) begin
      cnt <= 8'h00;
    end else if (cnt + 8'h01 >= i_period) begin
      cnt <= 8'h00;
      o_kick <= ~o_kick;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule // ssw_cpu_model

/* verif/supply_supervisor_watchdog_test.sv */
// self-checking bench: standard and latch-free supervisors share one set of pins
// assumes short tick, delay and timeout parameters so the run stays brief
`timescale 1ns/1ns
module supply_supervisor_watchdog_test;
  import ssw_pkg::*;
  localparam int TK = 4;
  localparam int DL = 5;
  localparam int TO = 10;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_supply_good = 1'b0;
  logic i_manual_reset_n = 1'b1;
  logic i_kick_floating = 1'b0;
  logic [7:0] period = 8'h00;
  logic kick;
  logic o_reset_n, o_reset, lf_reset_n, lf_reset;
  ssw_state_t o_state, lf_state;
  logic [2:0] bad_sh = 3'h7;
  int miscompares = 0;
  int checked = 0;
  always #5 i_clk = ~i_clk;
  ssw_cpu_model cpu (.i_clk(i_clk), .i_period(period), .o_kick(kick));
  ssw_top #(.TICK_CYCLES(TK), .DELAY_TICKS(DL), .TIMEOUT_TICKS(TO)) dut (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_supply_good(i_supply_good), .i_manual_reset_n(i_manual_reset_n), .i_watchdog_kick_in(kick),
    .i_kick_floating(i_kick_floating), .o_reset_n(o_reset_n), .o_reset(o_reset), .o_state(o_state));
  ssw_top #(.TICK_CYCLES(TK), .DELAY_TICKS(DL), .TIMEOUT_TICKS(TO), .LATCH_FREE(1'b1)) dut_lf (.i_clk(i_clk),
    .i_resetn(i_resetn), .i_supply_good(i_supply_good), .i_manual_reset_n(i_manual_reset_n),
    .i_watchdog_kick_in(kick), .i_kick_floating(i_kick_floating), .o_reset_n(lf_reset_n), .o_reset(lf_reset),
    .o_state(lf_state));

  task automatic chk(input string what, input logic seen, input logic exp);
    checked++;
    if (seen !== exp) begin
      $display("Error %s expected %b seen %b", what, exp, seen);
      miscompares++;
    end
  endtask

  task automatic test_done();
    if (miscompares == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // reference: a bad pin combination forces reset two sync flops plus one output flop later
  always @(posedge i_clk) bad_sh <= {bad_sh[1:0], ~(i_supply_good & i_manual_reset_n)};
  always @(negedge i_clk) begin
    if (bad_sh[2]) begin
      chk("forced reset", o_reset_n, 1'b0);
      chk("forced reset latch free", lf_reset_n, 1'b0);
    end
    chk("high output", o_reset, ~o_reset_n);
    chk("state vs output", o_state === st_run, o_reset_n);
  end

  task automatic drive(input logic sup, input logic man);
    @(posedge i_clk);
    i_supply_good <= sup;
    i_manual_reset_n <= man;
    @(negedge i_clk);
  endtask

  // counts negedges until the chosen output reaches lvl and checks the count lies in [lo, hi]
  task automatic await(input string what, input bit lf, input logic lvl, input int lo, input int hi);
    int k;
    k = 0;
    while ((lf ? lf_reset_n : o_reset_n) !== lvl && k <= hi) begin
      @(negedge i_clk);
      k++;
    end
    chk({what, " early"}, k >= lo, 1'b1);
    chk({what, " late"}, k <= hi, 1'b1);
  endtask

  task automatic kick_on();
    @(posedge i_clk);
    period <= 8'(2 + $urandom % 19);
  endtask

  // stop right after a toggle so the last edge is seen while still running
  task automatic stop_kick();
    @(kick);
    period <= 8'h00;
    repeat (3) @(negedge i_clk);
  endtask

  initial begin
    repeat (5000) @(posedge i_clk);
    miscompares++;
    test_done();
  end

  initial begin
    void'($urandom(6));
    repeat (10) @(posedge i_clk);
    i_resetn <= 1'b1;
    drive(1'b1, 1'b1);
    await("power-up release", 1'b0, 1'b1, (DL - 1) * TK, DL * TK + 8);
    kick_on();
    for (int c = 0; c < 3; c++) begin
      stop_kick();
      drive(1'(c == 1), 1'(c == 2));
      await("bad input", 1'b0, 1'b0, 0, 4);
      drive(1'b1, 1'b1);
      await("delayed release", 1'b0, 1'b1, (DL - 1) * TK, DL * TK + 8);
      kick_on();
    end
    stop_kick();
    await("timeout", 1'b0, 1'b0, (TO - 1) * TK - 4, TO * TK + 6);
    await("timeout pulse", 1'b0, 1'b1, (DL - 1) * TK, DL * TK + 2);
    await("second timeout", 1'b0, 1'b0, (TO - 1) * TK, TO * TK + 2);
    await("second pulse", 1'b0, 1'b1, (DL - 1) * TK, DL * TK + 2);
    kick_on();
    stop_kick();
    @(posedge i_clk);
    i_kick_floating <= 1'b1;
    repeat (3 * TO * TK) begin
      @(negedge i_clk);
      chk("floating kick", o_reset_n, 1'b1);
    end
    kick_on();
    @(posedge i_clk);
    i_kick_floating <= 1'b0;
    // kicks keep running through a manual reset: only the latch-free copy may come back
    drive(1'b1, 1'b0);
    await("manual reset", 1'b0, 1'b0, 0, 4);
    repeat (2 * TK) @(negedge i_clk);
    drive(1'b1, 1'b1);
    await("latch-free release", 1'b1, 1'b1, (DL - 1) * TK, DL * TK + 8);
    repeat (60) begin
      @(negedge i_clk);
      chk("latched reset", o_reset_n, 1'b0);
    end
    stop_kick();
    @(posedge i_clk);
    i_resetn <= 1'b0;
    repeat (10) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(negedge i_clk);
    await("latch cleared", 1'b0, 1'b1, (DL - 1) * TK, DL * TK + 10);
    kick_on();
    repeat (2 * TO * TK) @(negedge i_clk);
    chk("latch-free running", lf_reset_n, 1'b1);
    chk("standard running", o_reset_n, 1'b1);
    test_done();
  end
endmodule // supply_supervisor_watchdog_test
